// ---- queue_defines.vh ----
// constants and field layout of the queued serial command engine
`ifndef QUEUE_DEFINES_VH
`define QUEUE_DEFINES_VH
`define RX_REGION 2'h0
`define TX_REGION 2'h1
`define CMD_REGION 3'h4
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
`define CMD_HOLD 7
`define CMD_WIDE 6
`define CMD_POST 5
`define CMD_LEAD 4
`define SHORT_WORD_BITS 5'h08
`define FULL_WORD_BITS 5'h10
`define STD_POST_DELAY 14'h0011
`define POST_DELAY_SHIFT 5
`define POST_DELAY_ZERO 14'h2000
`define MIN_BAUD 8'h02
`define FIFO_DEPTH 16
`define FIFO_ADDR 4
`define ENTRY_WIDTH 20
`endif

// ---- queue_fifo.v ----
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module queue_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 16,
  parameter ADDR = 4
) (
  input wire clk,
  input wire reset,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [ADDR-1:0] writePtr;
  reg [ADDR-1:0] readPtr;
  reg [ADDR:0] count;
  wire push;
  wire pop;
  localparam [ADDR:0] FULL_COUNT = DEPTH;

  assign inReady = (count != FULL_COUNT);
  assign outValid = (count != {(ADDR+1){1'b0}});
  assign outData = store[readPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always @(posedge clk) begin
    if (push) begin
      store[writePtr] <= inData;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      writePtr <= {ADDR{1'b0}};
      readPtr <= {ADDR{1'b0}};
      count <= {(ADDR+1){1'b0}};
    end else begin
      if (push) begin
        writePtr <= writePtr + 1'b1;
      end
      if (pop) begin
        readPtr <= readPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // queue_fifo

// ---- queued_serial_command_ram.v ----
// queue memories and command engine of the queued serial master
`timescale 1ns/1ps
`include "queue_defines.vh"
module queued_serial_command_ram #(
  parameter [13:0] POST_DELAY_ZERO_CYCLES = `POST_DELAY_ZERO
) (
  input wire clk,
  input wire reset,
  input wire hostSelect,
  input wire hostWrite,
  input wire [1:0] hostSize,
  input wire [6:0] hostAddr,
  input wire [31:0] hostWriteData,
  output reg [31:0] hostReadData,
  output reg hostAck,
  input wire serialEnable,
  input wire masterMode,
  input wire restartQueue,
  input wire [3:0] queueStartPointer,
  input wire [3:0] queueEndPointer,
  input wire wrapEnable,
  input wire wrapToStart,
  input wire [3:0] bitsPerTransfer,
  input wire clockPolarity,
  input wire clockPhase,
  input wire [7:0] baudDivider,
  input wire [7:0] postTransferDelayCount,
  input wire [6:0] selectToClockDelayCount,
  input wire [3:0] serialPortPinData,
  input wire selectZeroIsOutput,
  input wire clearFinished,
  input wire clearModeFault,
  output reg [3:0] completedQueuePointer,
  output reg queueFinishedFlag,
  output reg modeFaultFlag,
  output wire queueBusy,
  output reg serialClock,
  output wire masterOut,
  input wire masterIn,
  output reg [3:0] peripheralSelect,
  output wire [3:0] peripheralSelectOe,
  input wire peripheralSelectZeroIn
);
  // ==========================================================
  // state and storage
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_FETCH = 5'h02;
  localparam [4:0] S_LEAD = 5'h04;
  localparam [4:0] S_SHIFT = 5'h08;
  localparam [4:0] S_TRAIL = 5'h10;

  reg [15:0] rxRam [0:15];
  reg [15:0] txRam [0:15];
  reg [7:0] cmdRam [0:15];
  reg [4:0] state;
  reg [3:0] ptr;
  reg [7:0] cmd;
  reg [15:0] shiftOut;
  reg [15:0] shiftIn;
  reg [4:0] bitLen;
  reg [5:0] edgeCount;
  reg [7:0] halfCount;
  reg [13:0] delayCount;
  reg pushPending;
  reg restartPending;
  reg misoMeta;
  reg misoSync;
  reg slaveSelMeta;
  reg slaveSelSync;
  integer i;

  // ==========================================================
  // host access decode
  wire rxHit = hostSelect && (hostAddr[6:5] == `RX_REGION);
  wire txHit = hostSelect && (hostAddr[6:5] == `TX_REGION);
  wire cmdHit = hostSelect && (hostAddr[6:4] == `CMD_REGION);
  wire isByte = (hostSize == `SIZE_BYTE);
  wire isLong = (hostSize == `SIZE_LONG);
  wire [15:0] rxHiEn;
  wire [15:0] rxLoEn;
  wire [15:0] txHiEn;
  wire [15:0] txLoEn;
  wire [15:0] cmdEn;
  wire [15:0] wordData [0:15];
  wire [7:0] byteData [0:15];

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : lanes
      localparam [3:0] idx = g;
      wire wordHit = isLong ? (hostAddr[4:2] == idx[3:1]) :
                              (hostAddr[4:1] == idx);
      wire hiLane = wordHit && (!isByte || !hostAddr[0]);
      wire loLane = wordHit && (!isByte || hostAddr[0]);
      wire byteHit = isLong ? (hostAddr[3:2] == idx[3:2]) :
                     isByte ? (hostAddr[3:0] == idx) :
                              (hostAddr[3:1] == idx[3:1]);
      // big-endian lanes: lower address carries the upper byte
      assign rxHiEn[g] = hostWrite && rxHit && hiLane;
      assign rxLoEn[g] = hostWrite && rxHit && loLane;
      assign txHiEn[g] = hostWrite && txHit && hiLane;
      assign txLoEn[g] = hostWrite && txHit && loLane;
      assign cmdEn[g] = hostWrite && cmdHit && byteHit;
      assign wordData[g] = isLong ?
        (idx[0] ? hostWriteData[15:0] : hostWriteData[31:16]) :
        (isByte ? {2{hostWriteData[7:0]}} : hostWriteData[15:0]);
      assign byteData[g] = isLong ?
        hostWriteData[31-8*g%32 -: 8] :
        (isByte || idx[0]) ? hostWriteData[7:0] : hostWriteData[15:8];
    end
  endgenerate

  // ==========================================================
  // received word buffer between shifter and receive memory
  wire fifoInReady;
  wire fifoOutValid;
  wire [19:0] fifoOutData;
  wire drainReady = !(|rxHiEn || |rxLoEn);
  wire drain = fifoOutValid && drainReady;

  queue_fifo #(
    .WIDTH(`ENTRY_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .ADDR(`FIFO_ADDR)
  ) rxBuffer (
    .clk(clk),
    .reset(reset),
    .inValid(pushPending),
    .inReady(fifoInReady),
    .inData({ptr, shiftIn}),
    .outValid(fifoOutValid),
    .outReady(drainReady),
    .outData(fifoOutData)
  );

  // ==========================================================
  // memories
  always @(posedge clk) begin
    for (i = 0; i < 16; i = i + 1) begin
      if (rxHiEn[i]) begin
        rxRam[i][15:8] <= wordData[i][15:8];
      end
      if (rxLoEn[i]) begin
        rxRam[i][7:0] <= wordData[i][7:0];
      end
      if (drain && fifoOutData[19:16] == i[3:0]) begin
        rxRam[i] <= fifoOutData[15:0];
      end
      if (txHiEn[i]) begin
        txRam[i][15:8] <= wordData[i][15:8];
      end
      if (txLoEn[i]) begin
        txRam[i][7:0] <= wordData[i][7:0];
      end
      if (cmdEn[i]) begin
        cmdRam[i] <= byteData[i];
      end
    end
  end

  // ==========================================================
  // host read path
  reg [31:0] readValue;
  reg [15:0] readWordA;
  reg [15:0] readWordB;
  reg [3:0] wordIdx;
  reg [3:0] cmdIdx;

  always @* begin
    wordIdx = isLong ? {hostAddr[4:2], 1'b0} : hostAddr[4:1];
    cmdIdx = isLong ? {hostAddr[3:2], 2'b00} : {hostAddr[3:1], 1'b0};
    readWordA = 16'h0000;
    readWordB = 16'h0000;
    readValue = 32'h0000_0000;
    if (rxHit || txHit) begin
      readWordA = rxHit ? rxRam[wordIdx] : txRam[wordIdx];
      readWordB = rxHit ? rxRam[wordIdx | 4'h1] : txRam[wordIdx | 4'h1];
      if (isLong) begin
        readValue = {readWordA, readWordB};
      end else if (isByte) begin
        readValue = {24'h00_0000,
                     hostAddr[0] ? readWordA[7:0] : readWordA[15:8]};
      end else begin
        readValue = {16'h0000, readWordA};
      end
    end else if (cmdHit) begin
      if (isLong) begin
        readValue = {cmdRam[cmdIdx], cmdRam[cmdIdx | 4'h1],
                     cmdRam[cmdIdx | 4'h2], cmdRam[cmdIdx | 4'h3]};
      end else if (isByte) begin
        readValue = {24'h00_0000, cmdRam[hostAddr[3:0]]};
      end else begin
        readValue = {16'h0000, cmdRam[cmdIdx], cmdRam[cmdIdx | 4'h1]};
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      hostAck <= 1'b0;
      hostReadData <= 32'h0000_0000;
    end else begin
      hostAck <= hostSelect;
      if (hostSelect && !hostWrite) begin
        hostReadData <= readValue;
      end
    end
  end

  // ==========================================================
  // pin synchronisers
  always @(posedge clk) begin
    if (reset) begin
      misoMeta <= 1'b0;
      misoSync <= 1'b0;
      slaveSelMeta <= 1'b1;
      slaveSelSync <= 1'b1;
    end else begin
      misoMeta <= masterIn;
      misoSync <= misoMeta;
      slaveSelMeta <= peripheralSelectZeroIn;
      slaveSelSync <= slaveSelMeta;
    end
  end

  // ==========================================================
  // command engine
  wire active = serialEnable && masterMode && (baudDivider >= `MIN_BAUD);
  wire [7:0] nextCmd = cmdRam[ptr];
  wire [4:0] wideLen = (bitsPerTransfer == 4'h0) ? `FULL_WORD_BITS :
                       {1'b0, bitsPerTransfer};
  wire [4:0] nextLen = nextCmd[`CMD_WIDE] ? wideLen :
                       `SHORT_WORD_BITS;
  wire [13:0] leadDelay = !nextCmd[`CMD_LEAD] ? {6'h00, baudDivider} :
    (selectToClockDelayCount == 7'h00) ? 14'h0001 :
    {7'h00, selectToClockDelayCount};
  wire [13:0] postDelay = !cmd[`CMD_POST] ? `STD_POST_DELAY :
    (postTransferDelayCount == 8'h00) ? POST_DELAY_ZERO_CYCLES :
    {1'b0, postTransferDelayCount, 5'h00};
  wire [5:0] lastEdge = {bitLen, 1'b0} - 6'h01;
  wire leading = !edgeCount[0];
  wire trailDone = (state == S_TRAIL) && (delayCount == 14'h0001);
  wire finishEvent = trailDone && (ptr == queueEndPointer);
  wire faultEvent = serialEnable && masterMode && !selectZeroIsOutput &&
                    !slaveSelSync;

  assign queueBusy = (state != S_IDLE);
  assign masterOut = shiftOut[15];
  assign peripheralSelectOe = (serialEnable && masterMode) ?
                              {3'b111, selectZeroIsOutput} : 4'h0;

  always @(posedge clk) begin
    if (reset) begin
      state <= S_IDLE;
      ptr <= 4'h0;
      cmd <= 8'h00;
      shiftOut <= 16'h0000;
      shiftIn <= 16'h0000;
      bitLen <= `SHORT_WORD_BITS;
      edgeCount <= 6'h00;
      halfCount <= 8'h00;
      delayCount <= 14'h0000;
      pushPending <= 1'b0;
      restartPending <= 1'b0;
      completedQueuePointer <= 4'h0;
      serialClock <= 1'b0;
      peripheralSelect <= 4'h0;
    end else if (!active || modeFaultFlag) begin
      state <= S_IDLE;
      pushPending <= 1'b0;
      restartPending <= 1'b0;
      serialClock <= clockPolarity;
      peripheralSelect <= serialPortPinData;
    end else begin
      if (restartQueue && state != S_IDLE) begin
        restartPending <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          serialClock <= clockPolarity;
          if (restartQueue) begin
            ptr <= queueStartPointer;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          // wait for buffer room so a finished word is never dropped
          if (fifoInReady) begin
            cmd <= nextCmd;
            shiftOut <= txRam[ptr] << (5'h10 - nextLen);
            shiftIn <= 16'h0000;
            bitLen <= nextLen;
            // first serial edge lands exactly the lead delay after the selects
            delayCount <= leadDelay - 14'h0001;
            edgeCount <= 6'h00;
            halfCount <= 8'h01;
            peripheralSelect <= nextCmd[3:0];
            state <= (leadDelay == 14'h0001) ? S_SHIFT : S_LEAD;
          end
        end
        S_LEAD: begin
          if (delayCount == 14'h0001) begin
            state <= S_SHIFT;
          end else begin
            delayCount <= delayCount - 14'h0001;
          end
        end
        S_SHIFT: begin
          if (halfCount == 8'h01) begin
            halfCount <= baudDivider;
            serialClock <= ~serialClock;
            edgeCount <= edgeCount + 6'h01;
            if (leading ^ clockPhase) begin
              shiftIn <= {shiftIn[14:0], misoSync};
            end else if (!(clockPhase && edgeCount == 6'h00)) begin
              shiftOut <= {shiftOut[14:0], 1'b0};
            end
            if (edgeCount == lastEdge) begin
              pushPending <= 1'b1;
              delayCount <= postDelay;
              state <= S_TRAIL;
            end
          end else begin
            halfCount <= halfCount - 8'h01;
          end
        end
        S_TRAIL: begin
          if (pushPending) begin
            completedQueuePointer <= ptr;
          end
          pushPending <= 1'b0;
          if (!cmd[`CMD_HOLD]) begin
            peripheralSelect <= serialPortPinData;
          end
          if (trailDone) begin
            restartPending <= 1'b0;
            state <= S_FETCH;
            if (restartPending) begin
              ptr <= queueStartPointer;
            end else if (ptr == queueEndPointer) begin
              if (wrapEnable) begin
                ptr <= wrapToStart ? queueStartPointer : 4'h0;
              end else begin
                state <= S_IDLE;
              end
            end else begin
              ptr <= ptr + 4'h1;
            end
          end else begin
            delayCount <= delayCount - 14'h0001;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // status flags, a set in the clearing cycle wins
  always @(posedge clk) begin
    if (reset) begin
      queueFinishedFlag <= 1'b0;
      modeFaultFlag <= 1'b0;
    end else begin
      if (finishEvent) begin
        queueFinishedFlag <= 1'b1;
      end else if (clearFinished) begin
        queueFinishedFlag <= 1'b0;
      end
      if (faultEvent) begin
        modeFaultFlag <= 1'b1;
      end else if (clearModeFault) begin
        modeFaultFlag <= 1'b0;
      end
    end
  end
endmodule // queued_serial_command_ram

// ---- qscr_properties.sv ----
// concurrent checks on the queued serial command engine ports
`timescale 1ns/1ps
module qscr_properties (
  input wire clk,
  input wire reset,
  input wire hostSelect,
  input wire hostWrite,
  input wire [6:0] hostAddr,
  input wire [31:0] hostReadData,
  input wire hostAck,
  input wire serialEnable,
  input wire masterMode,
  input wire clockPolarity,
  input wire [3:0] queueEndPointer,
  input wire selectZeroIsOutput,
  input wire clearFinished,
  input wire clearModeFault,
  input wire [3:0] completedQueuePointer,
  input wire queueFinishedFlag,
  input wire modeFaultFlag,
  input wire queueBusy,
  input wire serialClock,
  input wire [3:0] peripheralSelectOe,
  input wire peripheralSelectZeroIn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ======
  // host port
  a_ack_follows: assert property (hostSelect |=> hostAck)
    else $error("access not acknowledged");
  a_no_stray_ack: assert property (!hostSelect |=> !hostAck)
    else $error("acknowledge without access");
  a_unmapped_zero: assert property (
    hostSelect && !hostWrite && hostAddr > 7'h4F |=> hostReadData == 32'h0)
    else $error("unmapped read not zero");
  // ======
  // queue engine
  a_pointer_busy: assert property (
    !$stable(completedQueuePointer) |-> $past(queueBusy))
    else $error("pointer moved while idle");
  a_finish_at_end: assert property (
    $rose(queueFinishedFlag) |-> completedQueuePointer == queueEndPointer)
    else $error("finished before end command");
  a_finish_sticky: assert property (
    queueFinishedFlag && !clearFinished |=> queueFinishedFlag)
    else $error("finished flag lost");
  a_clock_parked: assert property (
    !queueBusy && !$past(queueBusy) |-> serialClock == clockPolarity)
    else $error("serial clock not parked");
  a_clock_busy: assert property (
    !$stable(serialClock) |-> $past(queueBusy))
    else $error("serial clock moved while idle");
  a_fault_set: assert property (
    (masterMode && serialEnable && !selectZeroIsOutput
     && !peripheralSelectZeroIn) [*3] |=> modeFaultFlag)
    else $error("mode fault not raised");
  a_fault_halts: assert property (modeFaultFlag |=> !queueBusy)
    else $error("engine runs under mode fault");
  a_fault_sticky: assert property (
    modeFaultFlag && !clearModeFault |=> modeFaultFlag)
    else $error("mode fault flag lost");
  a_select_zero_pin: assert property (peripheralSelectOe ==
    ((serialEnable && masterMode) ? {3'h7, selectZeroIsOutput} : 4'h0))
    else $error("select enables wrong");
endmodule // qscr_properties

bind queued_serial_command_ram qscr_properties chk_u (.clk(clk),
  .reset(reset), .hostSelect(hostSelect), .hostWrite(hostWrite),
  .hostAddr(hostAddr), .hostReadData(hostReadData), .hostAck(hostAck),
  .serialEnable(serialEnable), .masterMode(masterMode),
  .clockPolarity(clockPolarity), .queueEndPointer(queueEndPointer),
  .selectZeroIsOutput(selectZeroIsOutput), .clearFinished(clearFinished),
  .clearModeFault(clearModeFault),
  .completedQueuePointer(completedQueuePointer),
  .queueFinishedFlag(queueFinishedFlag), .modeFaultFlag(modeFaultFlag),
  .queueBusy(queueBusy), .serialClock(serialClock),
  .peripheralSelectOe(peripheralSelectOe),
  .peripheralSelectZeroIn(peripheralSelectZeroIn));

// ---- serial_peripheral_model.sv ----
// behavioural serial peripheral answering on the master data input
`timescale 1ns/1ps
module serial_peripheral_model #(
  parameter [15:0] REPLY = 16'h9C36
) (
  input wire serialClock,
  input wire [3:0] peripheralSelect,
  input wire masterOut,
  output logic masterIn,
  output logic [31:0] heard,
  output int edgeCount,
  output int selectCount
);
  logic [15:0] shifter = REPLY;
  wire selected = |peripheralSelect;
  initial heard = 32'h0000_0000;
  initial edgeCount = 0;
  initial selectCount = 0;
  always @(posedge selected) begin
    shifter = REPLY;
    selectCount++;
  end
  // capture on leading edge, change on trailing edge
  always @(posedge serialClock) if (selected) begin
    heard = {heard[30:0], masterOut};
    edgeCount++;
  end
  always @(negedge serialClock) if (selected)
    shifter = {shifter[14:0], shifter[15]};
  // released line shows the inverse so stale data never matches
  always @* masterIn = selected ? shifter[15] : ~shifter[15];
endmodule // serial_peripheral_model

// ---- testbench.sv ----
// self-checking bench for the queued serial command memories
`timescale 1ns/1ps
module testbench;
  logic clk, reset, hostSelect, hostWrite, hostAck, serialEnable;
  logic masterMode, restartQueue, wrapEnable, wrapToStart, clockPolarity;
  logic clockPhase, selectZeroIsOutput, clearFinished, clearModeFault;
  logic queueFinishedFlag, modeFaultFlag, queueBusy, serialClock;
  logic masterOut, masterIn, peripheralSelectZeroIn;
  logic [1:0] hostSize;
  logic [6:0] hostAddr, selectToClockDelayCount;
  logic [31:0] hostWriteData, hostReadData, rd, heard;
  logic [3:0] queueStartPointer, queueEndPointer, bitsPerTransfer;
  logic [3:0] serialPortPinData, completedQueuePointer, peripheralSelect;
  logic [3:0] peripheralSelectOe;
  logic [7:0] baudDivider, postTransferDelayCount;
  int edgeCount, selectCount, n_errors, checked, cycles;
  int cqpLog[$];

  queued_serial_command_ram #(.POST_DELAY_ZERO_CYCLES(14'h0040)) dut_u (
    .clk(clk), .reset(reset), .hostSelect(hostSelect),
    .hostWrite(hostWrite), .hostSize(hostSize), .hostAddr(hostAddr),
    .hostWriteData(hostWriteData), .hostReadData(hostReadData),
    .hostAck(hostAck), .serialEnable(serialEnable),
    .masterMode(masterMode), .restartQueue(restartQueue),
    .queueStartPointer(queueStartPointer),
    .queueEndPointer(queueEndPointer), .wrapEnable(wrapEnable),
    .wrapToStart(wrapToStart), .bitsPerTransfer(bitsPerTransfer),
    .clockPolarity(clockPolarity), .clockPhase(clockPhase),
    .baudDivider(baudDivider),
    .postTransferDelayCount(postTransferDelayCount),
    .selectToClockDelayCount(selectToClockDelayCount),
    .serialPortPinData(serialPortPinData),
    .selectZeroIsOutput(selectZeroIsOutput),
    .clearFinished(clearFinished), .clearModeFault(clearModeFault),
    .completedQueuePointer(completedQueuePointer),
    .queueFinishedFlag(queueFinishedFlag), .modeFaultFlag(modeFaultFlag),
    .queueBusy(queueBusy), .serialClock(serialClock),
    .masterOut(masterOut), .masterIn(masterIn),
    .peripheralSelect(peripheralSelect),
    .peripheralSelectOe(peripheralSelectOe),
    .peripheralSelectZeroIn(peripheralSelectZeroIn));

  serial_peripheral_model peer_u (.serialClock(serialClock),
    .peripheralSelect(peripheralSelect), .masterOut(masterOut),
    .masterIn(masterIn), .heard(heard), .edgeCount(edgeCount),
    .selectCount(selectCount));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      end_sim();
    end
  end
  always @(completedQueuePointer) if (!reset)
    cqpLog.push_back(completedQueuePointer);

  // ======
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  task automatic to_clock_rise(output int n);
    for (n = 0; n < 300 && serialClock !== 1'b1; n++) settle();
  endtask
  task automatic bus(input logic w, input logic [1:0] sz,
      input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    {hostSelect, hostWrite, hostSize, hostAddr, hostWriteData} =
      {1'b1, w, sz, a, d};
    @(posedge clk);
    #1;
    hostSelect = 0;
    rd = hostReadData;
    check(hostAck, 32'h0000_0001);
  endtask
  task automatic rdchk(input logic [1:0] sz, input logic [6:0] a,
      input logic [31:0] exp);
    bus(0, sz, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic run(input logic [3:0] s, input logic [3:0] e);
    int n;
    {queueStartPointer, queueEndPointer} = {s, e};
    @(posedge clk);
    #1 restartQueue = 1;
    @(posedge clk);
    #1 restartQueue = 0;
    for (n = 0; n < 60 && peripheralSelect === 4'h0; n++) settle();
  endtask
  task automatic wait_done;
    int n;
    for (n = 0; n < 4000 && queueFinishedFlag !== 1'b1; n++) settle();
    check(queueFinishedFlag, 32'h0000_0001);
  endtask

  // ======
  // scenarios
  task automatic first_queue;
    int n;
    bus(1, 2'h2, 7'h00, 32'hFFFF_FFFF);
    bus(1, 2'h2, 7'h04, 32'hFFFF_FFFF);
    bus(1, 2'h2, 7'h1C, 32'hFFFF_FFFF);
    bus(1, 2'h2, 7'h20, 32'h0000_00A5);
    bus(1, 2'h2, 7'h24, 32'hC3F0_1E2D);
    bus(1, 2'h2, 7'h40, 32'h0001_F646);
    run(4'h1, 4'h3);
    check(completedQueuePointer, 32'h0000_0000);
    to_clock_rise(n);
    check(n, 8);
    for (n = 0; n < 400 && completedQueuePointer !== 4'h1; n++) settle();
    for (n = 0; n < 400 && peripheralSelect !== 4'h6; n++) settle();
    check(n, 17);
    check(peripheralSelect, 32'h0000_0006);
    to_clock_rise(n);
    check(n, 5);
    for (n = 0; n < 800 && completedQueuePointer !== 4'h2; n++) settle();
    to_clock_rise(n);
    check(n, 32 * 2 + 8);
    wait_done();
    check(completedQueuePointer, 32'h0000_0003);
    check(cqpLog.size(), 3);
    foreach (cqpLog[i]) check(cqpLog[i], i + 1);
    check(heard, 32'hC3F0_1E2D);
    check(edgeCount, 40);
    check(selectCount, 2);
    check(peripheralSelect, 32'h0000_0000);
    check(serialClock, 32'h0000_0000);
  endtask
  task automatic ram_access;
    rdchk(2'h2, 7'h00, 32'hFFFF_009C);
    rdchk(2'h0, 7'h02, 32'h0000_0000);
    rdchk(2'h0, 7'h03, 32'h0000_009C);
    rdchk(2'h1, 7'h04, 32'h0000_9C36);
    rdchk(2'h1, 7'h06, 32'h0000_9C36);
    bus(1, 2'h0, 7'h1F, 32'h0000_007E);
    rdchk(2'h1, 7'h1E, 32'h0000_FF7E);
    rdchk(2'h2, 7'h24, 32'hC3F0_1E2D);
    rdchk(2'h2, 7'h40, 32'h0001_F646);
    rdchk(2'h1, 7'h50, 32'h0000_0000);
  endtask
  task automatic second_queue;
    @(posedge clk);
    #1 clearFinished = 1;
    @(posedge clk);
    #1 clearFinished = 0;
    check(queueFinishedFlag, 32'h0000_0000);
    run(4'h1, 4'h1);
    check(completedQueuePointer, 32'h0000_0003);
    wait_done();
    check(completedQueuePointer, 32'h0000_0001);
    check(heard[7:0], 32'h0000_00A5);
    check(edgeCount, 48);
  endtask
  task automatic mode_fault;
    selectZeroIsOutput = 0;
    peripheralSelectZeroIn = 0;
    repeat (5) @(posedge clk);
    #1;
    check(modeFaultFlag, 32'h0000_0001);
    check(queueBusy, 32'h0000_0000);
    peripheralSelectZeroIn = 1;
    repeat (3) @(posedge clk);
    #1 clearModeFault = 1;
    @(posedge clk);
    #1 clearModeFault = 0;
    check(modeFaultFlag, 32'h0000_0000);
  endtask

  task automatic end_sim;
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {reset, hostSelect, hostWrite, restartQueue} = 4'h8;
    {wrapEnable, wrapToStart, clockPolarity, clockPhase} = 4'h0;
    {clearFinished, clearModeFault} = 2'h0;
    {serialEnable, masterMode, selectZeroIsOutput} = 3'h7;
    peripheralSelectZeroIn = 1;
    {hostSize, hostAddr, hostWriteData} = 41'h0;
    baudDivider = 8'h08;
    postTransferDelayCount = 8'h02;
    selectToClockDelayCount = 7'h05;
    serialPortPinData = 4'h0;
    bitsPerTransfer = 4'h0;
    {queueStartPointer, queueEndPointer} = 8'h13;
    repeat (5) @(posedge clk);
    #1 reset = 0;
    first_queue();
    ram_access();
    second_queue();
    mode_fault();
    end_sim();
  end
endmodule // testbench
